/* logic/serial_mode_autodetect_pipe.sv */
// serial front end: framing auto-detect, pipe mode gate, wishbone registers
`timescale 1ns/10ps
`default_nettype none
`include "serial_pipe_consts.svh"
module serial_mode_autodetect_pipe #(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [7:0]                  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic      [31:0]                 wb_dat_o,
    output logic                             wb_ack_o,
    // stored framing setting
    input  wire logic                        saved_binary_i,
    output logic                             framing_store_o,
    // host serial bytes
    input  wire serial_pipe_pkg::stream_t    host_rx_i,
    output serial_pipe_pkg::stream_t         host_tx_o,
    // command parser feed
    output serial_pipe_pkg::cmd_byte_t       cmd_o,
    output logic                             echo_en_o,
    // remote peer
    input  wire serial_pipe_pkg::stream_t    peer_rx_i,
    output serial_pipe_pkg::stream_t         peer_tx_o,
    input  wire logic                        peer_sub_i,
    input  wire logic                        peer_unsub_i,
    input  wire logic                        peer_disc_i,
    // advertising
    output logic      [31:0]                 adv_key_o,
    output logic                             adv_key_en_o,
    // pipe pins
    input  wire logic                        pipe_req_n_i,
    output logic                             pipe_ready_n_o
);
    import serial_pipe_pkg::*;

    logic        ack_q;
    logic        set_framing_q;
    logic        profile_en_q;
    logic [31:0] key_q;
    logic        drop_seen_q;
    logic        boot_q;
    logic        binary_q;
    logic        req_meta_q;
    logic        req_sync_q;
    logic        req_prev_q;
    logic        sw_pipe_q;
    logic        sub_q;
    logic        data_mode_q;
    logic        trk_idle;
    logic        trk_done;
    logic        trk_drop;

    // bus decode
    wire logic       bus_req   = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic       wr        = bus_req && wb_we_i;
    wire logic       wr_ctrl   = wr && (wb_adr_i == `ADR_CTRL) && wb_sel_i[0];
    wire logic       wr_key    = wr && (wb_adr_i == `ADR_KEY);
    wire logic       wr_status = wr && (wb_adr_i == `ADR_STATUS) && wb_sel_i[0];
    wire logic       start_wr  = wr_ctrl && wb_dat_i[`CTRL_START];
    wire logic       drop_clr  = wr_status && wb_dat_i[`ST_DROP];

    // pin and pipe state
    wire logic       pin_low   = !req_sync_q;
    wire logic       pin_rise  = req_sync_q && !req_prev_q;
    wire logic       pipe_on   = pin_low || sw_pipe_q;
    wire logic       pipe_set  = start_wr || (peer_sub_i && profile_en_q);
    wire logic       pipe_clr  = peer_disc_i || (peer_unsub_i && pin_low == 1'b0) || pin_rise;
    wire logic       sw_pipe_d = pipe_set || (sw_pipe_q && !pipe_clr);
    wire logic       sub_d     = peer_sub_i || (sub_q && !(peer_unsub_i || peer_disc_i));
    wire logic       data_mode_d = pin_low || (sw_pipe_q && sub_q);

    // framing detect
    wire logic       cmd_byte  = host_rx_i.valid && !data_mode_q;
    wire logic       to_pipe   = host_rx_i.valid && data_mode_q;
    wire logic       is_hi     = (host_rx_i.data[7:6] == 2'b11);
    wire logic       is_txt    = (host_rx_i.data == `CH_SLASH) || (host_rx_i.data == `CH_S) ||
                                 (host_rx_i.data == `CH_G) || (host_rx_i.data == `CH_DOT);
    wire logic       bin_now   = binary_q ? !(trk_idle && is_txt) : is_hi;
    wire logic       binary_d  = boot_q ? saved_binary_i : (cmd_byte ? bin_now : binary_q);
    wire stream_t    trk_byte  = '{valid: cmd_byte && bin_now, data: host_rx_i.data};

    // read mux
    wire logic [31:0] status_w = {25'h0, drop_seen_q, trk_idle, sub_q,
                                  !pipe_ready_n_o, data_mode_q, pipe_on, binary_q};
    wire logic [31:0] ctrl_w   = {30'h0, profile_en_q, set_framing_q};
    wire logic [31:0] rdata    = (wb_adr_i == `ADR_CTRL)   ? ctrl_w   :
                                 (wb_adr_i == `ADR_KEY)    ? key_q    :
                                 (wb_adr_i == `ADR_STATUS) ? status_w : 32'h0;

    bin_frame_tracker #(
        .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
    ) u_tracker (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .byte_i (trk_byte),
        .idle_o (trk_idle),
        .done_o (trk_done),
        .drop_o (trk_drop)
    );

    // wishbone answer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q    <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            ack_q    <= bus_req;
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rdata : 32'h0;
        end
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            set_framing_q <= 1'b0;
            profile_en_q  <= 1'b0;
            drop_seen_q   <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                set_framing_q <= wb_dat_i[`CTRL_FRAMING];
                profile_en_q  <= wb_dat_i[`CTRL_PROFILE];
            end
            drop_seen_q <= trk_drop || (drop_seen_q && !drop_clr);
        end
    end

    // connection key, byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_q <= `KEY_RESET;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_key && wb_sel_i[i]) begin
                    key_q[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
                end
            end
        end
    end

    // pin synchroniser
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_meta_q <= 1'b1;
            req_sync_q <= 1'b1;
            req_prev_q <= 1'b1;
        end else begin
            req_meta_q <= pipe_req_n_i;
            req_sync_q <= req_meta_q;
            req_prev_q <= req_sync_q;
        end
    end

    // framing mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_q   <= 1'b1;
            binary_q <= 1'b0;
        end else begin
            boot_q   <= 1'b0;
            binary_q <= binary_d;
        end
    end

    // pipe state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_pipe_q   <= 1'b0;
            sub_q       <= 1'b0;
            data_mode_q <= 1'b0;
        end else begin
            sw_pipe_q   <= sw_pipe_d;
            sub_q       <= sub_d;
            data_mode_q <= data_mode_d;
        end
    end

    // data paths and pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_o           <= '0;
            peer_tx_o       <= '0;
            host_tx_o       <= '0;
            echo_en_o       <= 1'b1;
            pipe_ready_n_o  <= 1'b1;
            adv_key_o       <= `KEY_RESET;
            adv_key_en_o    <= 1'b0;
            framing_store_o <= 1'b0;
        end else begin
            cmd_o           <= '{valid: cmd_byte, binary: bin_now, data: host_rx_i.data};
            peer_tx_o       <= '{valid: to_pipe, data: host_rx_i.data};
            host_tx_o       <= '{valid: peer_rx_i.valid && data_mode_q, data: peer_rx_i.data};
            echo_en_o       <= !binary_d;
            pipe_ready_n_o  <= !(pipe_on && sub_q);
            adv_key_o       <= key_q;
            adv_key_en_o    <= pipe_on;
            framing_store_o <= set_framing_q;
        end
    end

    a_boot_text: assert property (@(posedge clk_i) disable iff (rst_i)
        (boot_q && !saved_binary_i) |=> !binary_q)
        else $error("text framing not used after reset");
    a_text_to_bin: assert property (@(posedge clk_i) disable iff (rst_i)
        (!boot_q && cmd_byte && !binary_q && is_hi) |=> binary_q && cmd_o.valid && cmd_o.binary)
        else $error("high byte did not switch to binary");
    a_bin_to_text: assert property (@(posedge clk_i) disable iff (rst_i)
        (!boot_q && cmd_byte && binary_q && trk_idle && is_txt) |=>
        !binary_q && cmd_o.valid && !cmd_o.binary)
        else $error("category byte did not switch to text");
    a_no_mid_switch: assert property (@(posedge clk_i) disable iff (rst_i)
        (!boot_q && cmd_byte && binary_q && !trk_idle) |=> binary_q)
        else $error("framing switched mid packet");
    a_store_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_ctrl |=> $stable(set_framing_q))
        else $error("stored framing changed without write");
    a_pipe_fwd: assert property (@(posedge clk_i) disable iff (rst_i)
        to_pipe |=> peer_tx_o.valid && !cmd_o.valid &&
        peer_tx_o.data == $past(host_rx_i.data))
        else $error("host byte not piped to peer");
    a_peer_fwd: assert property (@(posedge clk_i) disable iff (rst_i)
        (peer_rx_i.valid && data_mode_q) |=> host_tx_o.valid)
        else $error("peer byte not sent to host");
    a_pin_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        pin_low |=> data_mode_q)
        else $error("pin low did not enter pipe");
    a_start_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
        start_wr |=> sw_pipe_q)
        else $error("start command did not start pipe");
    a_sub_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        (peer_sub_i && !profile_en_q && !sw_pipe_q && !start_wr) |=> !sw_pipe_q)
        else $error("subscription entered pipe while disabled");
    a_ready_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        (sw_pipe_q && sub_q) |=> !pipe_ready_n_o)
        else $error("ready pin not asserted");
    a_pin_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        (pin_rise && !pipe_set) |=> !sw_pipe_q)
        else $error("pin release did not leave pipe");
    a_unsub_held: assert property (@(posedge clk_i) disable iff (rst_i)
        (peer_unsub_i && pin_low) |=> data_mode_q)
        else $error("unsubscribe ended pipe while pin held");
    a_cmd_resume: assert property (@(posedge clk_i) disable iff (rst_i)
        (host_rx_i.valid && !data_mode_q) |=> cmd_o.valid && !peer_tx_o.valid)
        else $error("parser not fed in command mode");

endmodule : serial_mode_autodetect_pipe
`default_nettype wire

/* logic/serial_pipe_consts.svh */
// constants for the serial framing detector and pipe gate
`ifndef SERIAL_PIPE_CONSTS_SVH
`define SERIAL_PIPE_CONSTS_SVH

`define ADR_CTRL        8'h00
`define ADR_KEY         8'h04
`define ADR_STATUS      8'h08

`define CTRL_FRAMING    0
`define CTRL_PROFILE    1
`define CTRL_START      2

`define ST_BINARY       0
`define ST_PIPE_ON      1
`define ST_DATA_MODE    2
`define ST_READY        3
`define ST_SUBSCRIBED   4
`define ST_BIN_IDLE     5
`define ST_DROP         6

`define KEY_RESET       32'h0000_0000
`define SUM_SEED        8'h99
`define HDR_LAST        2'h3
`define CH_SLASH        8'h2F
`define CH_S            8'h53
`define CH_G            8'h47
`define CH_DOT          8'h2E

`define CLK_HZ          25000000
`define TIMEOUT_MS      1000
`define TIMEOUT_CYC     ((`CLK_HZ / 1000) * `TIMEOUT_MS)

`endif

/* logic/serial_pipe_pkg.sv */
// types shared by the serial framing detector and pipe gate
package serial_pipe_pkg;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } stream_t;

    typedef struct packed {
        logic       valid;
        logic       binary;
        logic [7:0] data;
    } cmd_byte_t;

    typedef enum logic [1:0] {
        FR_IDLE = 2'b00,
        FR_HDR  = 2'b01,
        FR_BODY = 2'b11,
        FR_SUM  = 2'b10
    } frame_state_t;

endpackage : serial_pipe_pkg

/* logic/bin_frame_tracker.sv */
// binary packet tracker: header, payload length, checksum and timeout
`timescale 1ns/10ps
`default_nettype none
`include "serial_pipe_consts.svh"
module bin_frame_tracker #(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // binary bytes
    input  wire serial_pipe_pkg::stream_t byte_i,
    // status
    output logic                         idle_o,
    output logic                         done_o,
    output logic                         drop_o
);
    import serial_pipe_pkg::*;

    frame_state_t state_q;
    logic [1:0]   hdr_q;
    logic [7:0]   cnt_q;
    logic [7:0]   sum_q;
    logic [24:0]  tmo_q;

    wire logic [7:0] sum_next = sum_q + byte_i.data;
    wire logic       tmo_hit  = (state_q != FR_IDLE) &&
                                (tmo_q == 25'(TIMEOUT_CYCLES - 1));
    wire logic       sum_bad  = byte_i.valid && (state_q == FR_SUM) &&
                                (byte_i.data != sum_q);

    assign idle_o = (state_q == FR_IDLE);

    always_ff @(posedge clk_i) begin
        if (rst_i || state_q == FR_IDLE) begin
            tmo_q <= 25'h0;
        end else begin
            tmo_q <= tmo_q + 25'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= FR_IDLE;
            hdr_q   <= 2'h0;
            cnt_q   <= 8'h00;
            sum_q   <= 8'h00;
            done_o  <= 1'b0;
            drop_o  <= 1'b0;
        end else begin
            done_o <= byte_i.valid && (state_q == FR_SUM) && !sum_bad;
            drop_o <= tmo_hit || sum_bad;
            if (tmo_hit) begin
                state_q <= FR_IDLE;
            end else if (byte_i.valid) begin
                sum_q <= sum_next;
                case (state_q)
                    FR_IDLE: begin
                        state_q <= FR_HDR;
                        hdr_q   <= 2'h1;
                        sum_q   <= `SUM_SEED + byte_i.data;
                    end
                    FR_HDR: begin
                        hdr_q <= hdr_q + 2'h1;
                        if (hdr_q == 2'h1) begin
                            cnt_q <= byte_i.data;
                        end
                        if (hdr_q == `HDR_LAST) begin
                            state_q <= (cnt_q == 8'h00) ? FR_SUM : FR_BODY;
                        end
                    end
                    FR_BODY: begin
                        cnt_q <= cnt_q - 8'h01;
                        if (cnt_q == 8'h01) begin
                            state_q <= FR_SUM;
                        end
                    end
                    FR_SUM: begin
                        state_q <= FR_IDLE;
                    end
                    default: begin
                        state_q <= FR_IDLE;
                    end
                endcase
            end
        end
    end

    a_timeout_drop: assert property (@(posedge clk_i) disable iff (rst_i)
        tmo_hit |=> drop_o && idle_o)
        else $error("timed out packet not abandoned");
    a_sum_check: assert property (@(posedge clk_i) disable iff (rst_i)
        sum_bad |=> drop_o && !done_o && idle_o)
        else $error("bad checksum not discarded");
    a_idle_only_end: assert property (@(posedge clk_i) disable iff (rst_i)
        (byte_i.valid && state_q == FR_HDR && !tmo_hit) |=> !idle_o)
        else $error("tracker idle while header pending");

endmodule : bin_frame_tracker
`default_nettype wire

/* verification/host_mcu_model.sv */
// host controller model: serial bytes and pipe request pin
`timescale 1ns/10ps
`default_nettype none
module host_mcu_model (
    // clock and ready pin
    input  wire logic              clk_i,
    input  wire logic              pipe_ready_n_i,
    // host bytes and request pin
    output serial_pipe_pkg::stream_t host_rx_o,
    output logic                   pipe_req_n_o
);
    import serial_pipe_pkg::*;
    initial begin
        host_rx_o = '{1'b0, 8'h00};
        pipe_req_n_o = 1'b1;
    end
    task automatic send_byte(input logic [7:0] b);
        host_rx_o <= '{1'b1, b};
        @(posedge clk_i);
        host_rx_o <= '{1'b0, ~b};
    endtask : send_byte
    task automatic set_req(input logic lvl);
        pipe_req_n_o <= lvl;
        @(posedge clk_i);
    endtask : set_req
    // hold data until the ready pin shows, for at most 50 cycles; ok tells whether it did
    task automatic wait_ready(output logic ok);
        int n;
        n = 0;
        while (pipe_ready_n_i !== 1'b0 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        ok = (n < 50);
    endtask : wait_ready
endmodule : host_mcu_model
`default_nettype wire

/* verification/tb.sv */
// testbench for the serial framing detector and pipe gate
`timescale 1ns/10ps
`default_nettype none
`include "serial_pipe_consts.svh"
module tb;
    import serial_pipe_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, saved = 0;
    logic [2:0] ev_q = 0;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rd, wb_dat_o, adv_key_o;
    logic wb_ack_o, framing_store_o, echo_en_o, adv_key_en_o, pipe_ready_n_o, req_n, ok;
    stream_t host_rx, host_tx_o, peer_rx = '0, peer_tx_o;
    cmd_byte_t cmd_o;
    int fail_count = 0, tests_run = 0;
    always #20 clk_i = ~clk_i;
    serial_mode_autodetect_pipe #(.TIMEOUT_CYCLES(200)) u_serial_mode_autodetect_pipe (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .saved_binary_i(saved), .framing_store_o(framing_store_o),
        .host_rx_i(host_rx), .host_tx_o(host_tx_o), .cmd_o(cmd_o), .echo_en_o(echo_en_o),
        .peer_rx_i(peer_rx), .peer_tx_o(peer_tx_o), .peer_sub_i(ev_q[2]),
        .peer_unsub_i(ev_q[1]), .peer_disc_i(ev_q[0]), .adv_key_o(adv_key_o),
        .adv_key_en_o(adv_key_en_o), .pipe_req_n_i(req_n), .pipe_ready_n_o(pipe_ready_n_o));
    host_mcu_model u_host_mcu_model (.clk_i(clk_i), .pipe_ready_n_i(pipe_ready_n_o),
        .host_rx_o(host_rx), .pipe_req_n_o(req_n));
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) check(1'b0, 1'b1);
        cyc <= 0; stb <= 0;
        @(posedge clk_i);
    endtask : wb
    task automatic hb(input logic [7:0] b, input logic cv, eb, pv);
        u_host_mcu_model.send_byte(b);
        @(negedge clk_i);
        check(cmd_o.valid, cv);
        if (cv) check({cmd_o.binary, cmd_o.data}, {eb, b});
        check(peer_tx_o.valid, pv);
        if (pv) check(peer_tx_o.data, b);
        @(posedge clk_i);
    endtask : hb
    task automatic ev(input logic [2:0] e);
        ev_q <= e;
        @(posedge clk_i);
        ev_q <= 3'h0;
        @(posedge clk_i);
    endtask : ev
    task automatic do_reset(input logic s);
        saved <= s; rst_i <= 1;
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
    endtask : do_reset
    task automatic t_reset;
        @(negedge clk_i);
        check({echo_en_o, pipe_ready_n_o, adv_key_o}, {2'b11, `KEY_RESET});
        @(posedge clk_i);
        wb(0, `ADR_STATUS, 0); check(rd[`ST_BINARY], 0);
        wb(0, 8'h0C, 0); check(rd, 0);
    endtask : t_reset
    task automatic t_detect;
        logic [7:0] pk[5] = '{8'hC0, 8'h00, 8'h53, 8'h01, 8'hAD};
        logic [7:0] tc[4] = '{`CH_SLASH, `CH_S, `CH_G, `CH_DOT};
        hb(8'h41, 1, 0, 0);
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 5; j++) begin
                hb(pk[j], 1, 1, 0);
                if (j == 1) wb(0, `ADR_STATUS, 0);
                if (j == 1) check(rd[`ST_BIN_IDLE], 0);
            end
            check({echo_en_o, framing_store_o}, 0);
            hb(tc[i], 1, 0, 0);
        end
    endtask : t_detect
    task automatic t_timeout;
        hb(8'hC0, 1, 1, 0);
        repeat (210) @(posedge clk_i);
        wb(0, `ADR_STATUS, 0); check(rd[6:5], 2'b11);
        hb(`CH_G, 1, 0, 0);
        wb(1, `ADR_STATUS, 32'h40); wb(0, `ADR_STATUS, 0); check(rd[`ST_DROP], 0);
        hb(8'hC0, 1, 1, 0);
        hb(8'h00, 1, 1, 0);
        hb(8'h00, 1, 1, 0);
        hb(8'h00, 1, 1, 0);
        hb(8'h00, 1, 1, 0);
        wb(0, `ADR_STATUS, 0); check(rd[6:5], 2'b11);
        hb(`CH_S, 1, 0, 0);
    endtask : t_timeout
    task automatic t_pin;
        wb(1, `ADR_KEY, 32'h11223344); check(adv_key_o, 32'h11223344);
        u_host_mcu_model.set_req(0);
        ev(3'b100);
        u_host_mcu_model.wait_ready(ok); check({ok, adv_key_en_o}, 2'b11);
        hb(8'h55, 0, 0, 1);
        peer_rx <= '{1'b1, 8'h66};
        @(posedge clk_i);
        peer_rx <= '{1'b0, 8'h99};
        @(negedge clk_i);
        check({host_tx_o.valid, host_tx_o.data}, 9'h166);
        @(posedge clk_i);
        ev(3'b010); hb(8'h2F, 0, 0, 1);
        u_host_mcu_model.set_req(1);
        repeat (4) @(posedge clk_i);
        check(pipe_ready_n_o, 1);
        wb(0, `ADR_STATUS, 0); check(rd[2:1], 0);
        hb(8'h41, 1, 0, 0);
    endtask : t_pin
    task automatic t_start;
        wb(1, `ADR_CTRL, 32'h4); ev(3'b100);
        u_host_mcu_model.wait_ready(ok); check(ok, 1);
        hb(8'h2E, 0, 0, 1);
        ev(3'b001); wb(0, `ADR_STATUS, 0); check(rd[3:1], 0);
        hb(8'h41, 1, 0, 0);
    endtask : t_start
    task automatic t_profile;
        ev(3'b100); wb(0, `ADR_STATUS, 0); check(rd[2:1], 0);
        ev(3'b010); wb(1, `ADR_CTRL, 32'h2); ev(3'b100);
        wb(0, `ADR_STATUS, 0); check(rd[2:1], 2'b11);
        ev(3'b010); wb(0, `ADR_STATUS, 0); check(rd[2:1], 0);
        hb(8'h53, 1, 0, 0);
        wb(1, `ADR_CTRL, 32'h3); check(framing_store_o, 1);
        wb(0, `ADR_STATUS, 0); check(rd[`ST_BINARY], 0);
    endtask : t_profile
    task automatic t_saved;
        do_reset(1); wb(0, `ADR_STATUS, 0); check(rd[`ST_BINARY], 1);
        check(framing_store_o, 0);
        hb(`CH_DOT, 1, 0, 0);
    endtask : t_saved
    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        final_report();
    end
    initial begin
        do_reset(0);
        t_reset(); t_detect(); t_timeout(); t_pin(); t_start(); t_profile(); t_saved();
        final_report();
    end
endmodule : tb
`default_nettype wire
